/* File: verilog/otp_sec_pkg.sv */
package otp_sec_pkg;

  // Security word bit positions
  localparam int SEC_JTAG_OFF     = 0;
  localparam int SEC_LINK_OFF     = 1;
  localparam int SEC_SECURE_BOOT  = 5;
  localparam int SEC_REDUNDANT    = 7;
  localparam int SEC_LOCK_LO      = 8;
  localparam int SEC_MASTER_LOCK  = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF    = 14;
  localparam int SEC_GP_LO        = 15;
  localparam int SEC_GP_HI        = 21;
  localparam int SEC_UID_LO       = 22;
  localparam int SEC_UID_HI       = 31;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;

  // Array geometry
  localparam int OTP_SECTORS = 4;
  localparam int OTP_ROWS    = 512;
  localparam int OTP_AW      = 11;
  localparam logic [15:0] OTP_WORDS = 16'h0800;
  localparam logic [10:0] BOOT_BASE = 11'h000;

  // Programming port resource identifiers
  localparam logic [23:0] RES_ID_ADDR = 24'h10_0200;
  localparam logic [23:0] RES_ID_DATA = 24'h20_0100;
  localparam logic [23:0] RES_ID_CTRL = 24'h10_0300;

  // Control port operation codes
  localparam logic [15:0] CTRL_READ     = 16'h0001;
  localparam logic [15:0] CTRL_PROG     = 16'h0002;
  localparam logic [15:0] CTRL_PROG_SEC = 16'h0003;
  localparam logic [1:0]  OP_NONE       = 2'h0;
  localparam logic [1:0]  OP_READ       = 2'h1;
  localparam logic [1:0]  OP_PROG       = 2'h2;
  localparam logic [1:0]  OP_PROG_SEC   = 2'h3;

  // Boot image check
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15_AB1E;

  typedef struct packed {
    logic              rd;
    logic              prog;
    logic              sec_sel;
    logic              redundant;
    logic [OTP_AW-1:0] addr;
    logic [31:0]       wdata;
  } otp_req_s;

  typedef struct packed {
    logic        rd_valid;
    logic        prog_done;
    logic [31:0] rdata;
  } otp_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        from_jtag;
    logic [23:0] res_id;
    logic [31:0] data;
  } port_wr_s;

endpackage

/* File: verilog/otp_program_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_program_gate (
  // Live security word
  input  wire logic [31:0] sec,
  input  wire logic        loaded,
  // Requested operation
  input  wire logic [1:0]  op,
  input  wire logic [15:0] addr,
  input  wire logic        from_jtag,
  // Verdict
  output logic             allow
);
  logic       in_range;
  logic [1:0] sector;
  logic       sector_lock;
  logic       jtag_block;

  always_comb begin
    in_range    = addr < otp_sec_pkg::OTP_WORDS;
    sector      = addr[otp_sec_pkg::OTP_AW-1 -: 2];
    sector_lock = sec[otp_sec_pkg::SEC_LOCK_LO + int'(sector)];
    jtag_block  = from_jtag & (sec[otp_sec_pkg::SEC_JTAG_OTP_OFF]
                  | sec[otp_sec_pkg::SEC_JTAG_OFF]);
    allow = 1'b0;
    if (loaded && !jtag_block) begin
      case (op)
        otp_sec_pkg::OP_READ:     allow = in_range;
        otp_sec_pkg::OP_PROG:     allow = in_range & ~sector_lock
                                  & ~sec[otp_sec_pkg::SEC_MASTER_LOCK];
        otp_sec_pkg::OP_PROG_SEC: allow = ~sec[otp_sec_pkg::SEC_MASTER_LOCK];
        default:                  allow = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verilog/boot_image_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_image_loader #(
  parameter int SRAM_AW = 14
) (
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Control
  input  wire logic                           start,
  output logic                                done,
  output logic                                ok,
  // Array reads
  output logic                                rd_req,
  output logic [otp_sec_pkg::OTP_AW-1:0]      rd_addr,
  input  wire logic                           rd_valid,
  input  wire logic [31:0]                    rd_data,
  // Tile memory writes
  output logic                                sram_we,
  output logic [SRAM_AW-1:0]                  sram_addr,
  output logic [31:0]                         sram_wdata
);
  if (SRAM_AW < 4 || SRAM_AW > 16) begin : g_chk
    $error("SRAM_AW out of range");
  end

  typedef enum logic [3:0] {
    BL_IDLE = 4'h1, BL_REQ = 4'h2, BL_WAIT = 4'h4, BL_DONE = 4'h8
  } ldr_state_e;

  typedef struct packed {
    ldr_state_e                   st;
    logic [otp_sec_pkg::OTP_AW-1:0] addr;
    logic [11:0]                  count;
    logic [11:0]                  idx;
    logic [31:0]                  crc;
    logic                         ok;
    logic                         we;
    logic [SRAM_AW-1:0]           waddr;
    logic [31:0]                  wdata;
  } ldr_s;

  ldr_s r, n;

  // Reflected CRC, word taken least significant bit first
  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [31:0] w);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 32; i++) begin
      x = (x[0] ^ w[i]) ? ((x >> 1) ^ otp_sec_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  always_comb begin
    n    = r;
    n.we = 1'b0;
    case (r.st)
      BL_IDLE: if (start) begin
        n.addr = otp_sec_pkg::BOOT_BASE;
        n.idx  = 12'h000;
        n.crc  = otp_sec_pkg::CRC_INIT;
        n.st   = BL_REQ;
      end
      BL_REQ: n.st = BL_WAIT;
      BL_WAIT: if (rd_valid) begin
        n.addr = r.addr + 11'h001;
        n.idx  = r.idx + 12'h001;
        n.st   = BL_REQ;
        if (r.idx == 12'h000) begin
          n.crc   = crc_word(r.crc, rd_data);
          n.count = rd_data[11:0];
          // Count word, image and trailer must fit the array; the image alone the tile memory
          if (rd_data > 32'(otp_sec_pkg::OTP_WORDS) - 32'h2
              || rd_data > (32'h1 << SRAM_AW)) begin
            n.ok = 1'b0;
            n.st = BL_DONE;
          end
        end else if (r.idx == r.count + 12'h001) begin
          n.ok = (rd_data == otp_sec_pkg::CRC_SKIP) || (rd_data == ~r.crc);
          n.st = BL_DONE;
        end else begin
          n.crc   = crc_word(r.crc, rd_data);
          n.we    = 1'b1;
          n.waddr = SRAM_AW'(r.idx - 12'h001);
          n.wdata = rd_data;
        end
      end
      BL_DONE: n.st = BL_DONE;
      default: n.st = BL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r    <= '0;
      r.st <= BL_IDLE;
    end else begin
      r <= n;
    end
  end

  assign rd_req     = r.st == BL_REQ;
  assign rd_addr    = r.addr;
  assign done       = r.st == BL_DONE;
  assign ok         = r.ok;
  assign sram_we    = r.we;
  assign sram_addr  = r.waddr;
  assign sram_wdata = r.wdata;
endmodule
`default_nettype wire

/* File: verilog/otp_security_boot_control.sv */
// Notes on behaviour
// - secure boot fetches image from word 0
// - one array and register per tile instance
// - bit 0 blocks JTAG to tile state
// - bit 1 refuses switch accesses from tiles
// - bit 5 starts processor at OTP 0
// - bit 7 enables redundant array rows
// - bits 8-11 lock sectors 0-3 programming
// - bit 12 inhibits all programming entirely
// - bit 13 rejects JTAG reads and writes
// - bit 14 ignores, never drives debug pin
// - bits 21:15 readable general purpose field
// - bits 31:22 extend JTAG user ident
// - four sectors of 512 words, 8 KB
// - security word loaded before gating applies
// - image copied to SRAM, runs first
// - bit 5 overrides boot-source pins
// - count, words, CRC or skip trailer
`timescale 1ns/1ps
`default_nettype none
module otp_security_boot_control #(
  parameter int SRAM_AW = 14
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Array macro
  output otp_sec_pkg::otp_req_s          otp_req,
  input  wire otp_sec_pkg::otp_rsp_s     otp_rsp,
  // Programming ports
  input  wire otp_sec_pkg::port_wr_s     port_wr,
  output logic                           port_ready,
  output logic [31:0]                    prog_rdata,
  output logic                           prog_rd_valid,
  output logic                           prog_done,
  output logic                           prog_refused,
  // Tile memory loading
  output logic                           sram_we,
  output logic [SRAM_AW-1:0]             sram_addr,
  output logic [31:0]                    sram_wdata,
  // Processor boot
  input  wire logic [2:0]                boot_mode_pins,
  output logic [2:0]                     boot_mode,
  output logic                           boot_from_otp,
  output logic                           proc_release,
  output logic                           boot_failed,
  // Access gating
  input  wire logic                      jtag_req,
  output logic                           jtag_grant,
  input  wire logic                      link_req,
  output logic                           link_grant,
  // Debug sync pin
  input  wire logic                      debug_n_i,
  output logic                           debug_n_o,
  output logic                           debug_n_oe,
  input  wire logic                      debug_break,
  output logic                           debug_enter,
  // Security word view
  output logic [31:0]                    tile_security_config,
  output logic [6:0]                     gp_field,
  output logic [9:0]                     user_ident_extension
);
  // Loader write address and tile memory port share this width
  if (SRAM_AW < 4 || SRAM_AW > 16) begin : g_chk
    $error("SRAM_AW out of range");
  end

  typedef enum logic [3:0] {
    ST_LOAD = 4'h1, ST_LWAIT = 4'h2, ST_BOOT = 4'h4, ST_RUN = 4'h8
  } main_state_e;

  typedef struct packed {
    main_state_e           st;
    logic                  loaded;
    logic [31:0]           sec;
    logic [15:0]           addr_lat;
    logic [31:0]           data_lat;
    logic                  busy;
    logic [1:0]            op;
    otp_sec_pkg::otp_req_s req;
    logic [31:0]           rdata;
    logic                  rd_valid;
    logic                  done;
    logic                  refused;
    logic                  boot_otp;
    logic                  release_p;
    logic                  boot_err;
    logic                  ldr_start;
    logic [2:0]            mode_s1;
    logic [2:0]            mode_s2;
    logic                  dbg_s1;
    logic                  dbg_s2;
  } main_s;

  main_s r, n;

  logic                          ldr_done;
  logic                          ldr_ok;
  logic                          ldr_rd;
  logic [otp_sec_pkg::OTP_AW-1:0] ldr_addr;
  logic                          ldr_valid;
  logic [1:0]                    ctrl_op;
  logic                          allow;
  logic                          ctrl_wr;

  function automatic logic [1:0] decode_ctrl(input logic [15:0] c);
    case (c)
      otp_sec_pkg::CTRL_READ:     return otp_sec_pkg::OP_READ;
      otp_sec_pkg::CTRL_PROG:     return otp_sec_pkg::OP_PROG;
      otp_sec_pkg::CTRL_PROG_SEC: return otp_sec_pkg::OP_PROG_SEC;
      default:                    return otp_sec_pkg::OP_NONE;
    endcase
  endfunction

  assign ldr_valid = otp_rsp.rd_valid & (r.st == ST_BOOT);
  assign ctrl_op   = decode_ctrl(port_wr.data[15:0]);
  assign ctrl_wr   = port_wr.valid & port_ready
                     & (port_wr.res_id == otp_sec_pkg::RES_ID_CTRL);

  boot_image_loader #(
    .SRAM_AW (SRAM_AW)
  ) u_loader (
    .clk        (clk),
    .reset      (reset),
    .start      (r.ldr_start),
    .done       (ldr_done),
    .ok         (ldr_ok),
    .rd_req     (ldr_rd),
    .rd_addr    (ldr_addr),
    .rd_valid   (ldr_valid),
    .rd_data    (otp_rsp.rdata),
    .sram_we    (sram_we),
    .sram_addr  (sram_addr),
    .sram_wdata (sram_wdata)
  );

  otp_program_gate u_gate (
    .sec       (r.sec),
    .loaded    (r.loaded),
    .op        (ctrl_op),
    .addr      (r.addr_lat),
    .from_jtag (port_wr.from_jtag),
    .allow     (allow)
  );

  always_comb begin
    n             = r;
    n.rd_valid    = 1'b0;
    n.done        = 1'b0;
    n.refused     = 1'b0;
    n.release_p   = 1'b0;
    n.ldr_start   = 1'b0;
    n.req.rd      = 1'b0;
    n.req.prog    = 1'b0;
    n.req.sec_sel = 1'b0;
    // Boot pins and debug pin come from outside the clock domain
    n.mode_s1 = boot_mode_pins;
    n.mode_s2 = r.mode_s1;
    n.dbg_s1  = debug_n_i;
    n.dbg_s2  = r.dbg_s1;
    n.req.redundant = r.loaded & r.sec[otp_sec_pkg::SEC_REDUNDANT];
    case (r.st)
      ST_LOAD: begin
        n.req.rd      = 1'b1;
        n.req.sec_sel = 1'b1;
        n.req.addr    = '0;
        n.st          = ST_LWAIT;
      end
      ST_LWAIT: if (otp_rsp.rd_valid) begin
        n.sec    = otp_rsp.rdata;
        n.loaded = 1'b1;
        if (otp_rsp.rdata[otp_sec_pkg::SEC_SECURE_BOOT]) begin
          n.boot_otp  = 1'b1;
          n.ldr_start = 1'b1;
          n.st        = ST_BOOT;
        end else begin
          n.release_p = 1'b1;
          n.st        = ST_RUN;
        end
      end
      ST_BOOT: begin
        n.req.rd   = ldr_rd;
        n.req.addr = ldr_addr;
        if (ldr_done) begin
          // A failed check holds the processor, discontinuing boot
          if (ldr_ok) begin
            n.release_p = 1'b1;
          end else begin
            n.boot_err = 1'b1;
          end
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (r.busy) begin
          if (r.op == otp_sec_pkg::OP_READ && otp_rsp.rd_valid) begin
            n.rdata    = otp_rsp.rdata;
            n.rd_valid = 1'b1;
            n.busy     = 1'b0;
          end else if (r.op != otp_sec_pkg::OP_READ
                       && otp_rsp.prog_done) begin
            n.done = 1'b1;
            n.busy = 1'b0;
          end
        end else if (port_wr.valid) begin
          if (port_wr.res_id == otp_sec_pkg::RES_ID_ADDR) begin
            n.addr_lat = port_wr.data[15:0];
          end else if (port_wr.res_id == otp_sec_pkg::RES_ID_DATA) begin
            n.data_lat = port_wr.data;
          end else if (ctrl_wr) begin
            if (allow) begin
              n.busy        = 1'b1;
              n.op          = ctrl_op;
              n.req.addr    = r.addr_lat[otp_sec_pkg::OTP_AW-1:0];
              n.req.wdata   = r.data_lat;
              n.req.rd      = ctrl_op == otp_sec_pkg::OP_READ;
              n.req.prog    = ctrl_op != otp_sec_pkg::OP_READ;
              // Live word only changes at the next power-up load
              n.req.sec_sel = ctrl_op == otp_sec_pkg::OP_PROG_SEC;
            end else begin
              n.refused = 1'b1;
            end
          end
        end
      end
      default: n.st = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r     <= '0;
      r.sec <= otp_sec_pkg::SEC_RESET;
      r.st  <= ST_LOAD;
    end else begin
      r <= n;
    end
  end

  // Programming port handshake and answers
  assign port_ready    = (r.st == ST_RUN) & ~r.busy;
  assign otp_req       = r.req;
  assign prog_rdata    = r.rdata;
  assign prog_rd_valid = r.rd_valid;
  assign prog_done     = r.done;
  assign prog_refused  = r.refused;

  // Boot control; pins are ignored once the secure bit is seen
  assign boot_mode     = r.boot_otp ? 3'h0 : r.mode_s2;
  assign boot_from_otp = r.boot_otp;
  assign proc_release  = r.release_p;
  assign boot_failed   = r.boot_err;

  // Access gates stay shut until the word is loaded
  assign jtag_grant = jtag_req & r.loaded
                      & ~r.sec[otp_sec_pkg::SEC_JTAG_OFF];
  assign link_grant = link_req & r.loaded
                      & ~r.sec[otp_sec_pkg::SEC_LINK_OFF];

  // Debug pin only ever pulled low, and not at all when disabled
  assign debug_n_o   = 1'b0;
  assign debug_n_oe  = debug_break & r.loaded
                       & ~r.sec[otp_sec_pkg::SEC_DEBUG_OFF];
  assign debug_enter = ~r.dbg_s2 & r.loaded
                       & ~r.sec[otp_sec_pkg::SEC_DEBUG_OFF];

  // Register view and user fields
  assign tile_security_config = r.sec;
  assign gp_field = r.sec[otp_sec_pkg::SEC_GP_HI:otp_sec_pkg::SEC_GP_LO];
  assign user_ident_extension =
    r.sec[otp_sec_pkg::SEC_UID_HI:otp_sec_pkg::SEC_UID_LO];
endmodule
`default_nettype wire

/* File: sim/otp_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_array_model (
  // Clock, reset and pacing
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  slow,
  // Array port
  input  wire otp_sec_pkg::otp_req_s req,
  output otp_sec_pkg::otp_rsp_s      rsp
);
  logic [31:0]           mem [0:2047];
  logic [31:0]           sec_row;
  otp_sec_pkg::otp_req_s held;
  int                    wait_cnt;

  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
  end

  always @(posedge clk) begin
    rsp.rd_valid  <= 1'b0;
    rsp.prog_done <= 1'b0;
    // Stale data flips so it never passes for a fresh word
    rsp.rdata     <= ~rsp.rdata;
    if (reset) begin
      wait_cnt  <= 0;
      rsp.rdata <= 32'h0000_0000;
    end else if (req.rd || req.prog) begin
      held     <= req;
      wait_cnt <= slow ? 3 : 1;
    end else if (wait_cnt == 1) begin
      wait_cnt      <= 0;
      rsp.rd_valid  <= held.rd;
      rsp.prog_done <= held.prog;
      if (held.rd) begin
        rsp.rdata <= held.sec_sel ? sec_row : mem[held.addr];
      end
      // Fuses only ever go from 0 to 1
      if (held.prog && held.sec_sel) begin
        sec_row <= sec_row | held.wdata;
      end else if (held.prog) begin
        mem[held.addr] <= mem[held.addr] | held.wdata;
      end
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/otp_sec_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_sec_checker (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // Observed ports
  input wire otp_sec_pkg::otp_req_s otp_req,
  input wire logic                  proc_release,
  input wire logic                  boot_from_otp,
  input wire logic [2:0]            boot_mode,
  input wire logic                  jtag_req,
  input wire logic                  jtag_grant,
  input wire logic                  link_req,
  input wire logic                  link_grant,
  input wire logic                  debug_n_oe,
  input wire logic                  debug_enter,
  input wire logic [31:0]           tile_security_config,
  input wire logic [6:0]            gp_field,
  input wire logic [9:0]            user_ident_extension
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_load_first: assert property ($fell(reset) |-> ##[1:2] otp_req.rd
    && otp_req.sec_sel && otp_req.addr == 11'h000)
    else $error("security row not read first");
  a_jtag_gate: assert property (jtag_grant |-> jtag_req
    && !tile_security_config[0])
    else $error("debug access granted while disabled");
  a_link_gate: assert property (link_grant |-> link_req
    && !tile_security_config[1])
    else $error("switch access granted while disabled");
  a_debug_quiet: assert property (tile_security_config[14]
    |-> !debug_n_oe && !debug_enter)
    else $error("debug pin used while disabled");
  a_field_view: assert property (gp_field == tile_security_config[21:15]
    && user_ident_extension == tile_security_config[31:22])
    else $error("field views differ from security word");
  a_master_lock: assert property (otp_req.prog
    |-> !tile_security_config[12])
    else $error("programming under master lock");
  a_sector_lock: assert property (otp_req.prog && !otp_req.sec_sel
    |-> !tile_security_config[8 + otp_req.addr[10:9]])
    else $error("programming a locked sector");
  a_redundant_rows: assert property (otp_req.rd && !otp_req.sec_sel
    |-> otp_req.redundant == tile_security_config[7])
    else $error("redundant row select wrong");
  a_secure_start: assert property (proc_release
    && tile_security_config[5] |-> boot_from_otp && boot_mode == 3'h0)
    else $error("secure start not forced");

  c_secure_boot: cover property (proc_release && tile_security_config[5]);
  c_program: cover property (otp_req.prog);
  c_jtag: cover property (jtag_grant);
  c_link: cover property (link_grant);
endmodule

bind otp_security_boot_control otp_sec_checker u_chk (.clk, .reset,
  .otp_req, .proc_release, .boot_from_otp, .boot_mode, .jtag_req,
  .jtag_grant, .link_req, .link_grant, .debug_n_oe, .debug_enter,
  .tile_security_config, .gp_field, .user_ident_extension);
`default_nettype wire

/* File: sim/otp_security_boot_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_security_boot_control_bench;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  slow = 1'b0;
  otp_sec_pkg::otp_req_s otp_req;
  otp_sec_pkg::otp_rsp_s otp_rsp;
  otp_sec_pkg::port_wr_s port_wr = '0;
  logic                  port_ready, prog_rd_valid, prog_done, prog_refused;
  logic [31:0]           prog_rdata, sram_wdata, tile_security_config;
  logic                  sram_we, boot_from_otp, proc_release, boot_failed;
  logic [13:0]           sram_addr;
  logic [2:0]            boot_mode_pins = 3'h0;
  logic [2:0]            boot_mode;
  logic                  jtag_req = 1'b0, link_req = 1'b0, ext_n = 1'b1;
  logic                  debug_break = 1'b0, jtag_grant, link_grant;
  logic                  debug_n_o, debug_n_oe, debug_enter;
  wire logic             debug_n_i;
  logic [6:0]            gp_field;
  logic [9:0]            user_ident_extension;
  logic [31:0]           sec, seed = 32'h0000_0016;
  logic [31:0]           em [0:2047];
  logic [31:0]           img [$];
  int                    widx, cyc, n_errors, checks_done;

  // Shared pin: our side drives ext_n, high or low, unless the device drives
  assign debug_n_i = debug_n_oe === 1'b1 ? debug_n_o : ext_n;

  otp_security_boot_control u_dut (.clk, .reset, .otp_req, .otp_rsp,
    .port_wr, .port_ready, .prog_rdata, .prog_rd_valid, .prog_done,
    .prog_refused, .sram_we, .sram_addr, .sram_wdata, .boot_mode_pins,
    .boot_mode, .boot_from_otp, .proc_release, .boot_failed, .jtag_req,
    .jtag_grant, .link_req, .link_grant, .debug_n_i, .debug_n_o,
    .debug_n_oe, .debug_break, .debug_enter, .tile_security_config,
    .gp_field, .user_ident_extension);
  otp_array_model u_otp (.clk, .reset, .slow, .req(otp_req), .rsp(otp_rsp));

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      c = (c >> 1) ^ ((c[0] ^ w[i]) ? otp_sec_pkg::CRC_POLY : 32'h0);
    end
    return c;
  endfunction

  function automatic logic refused(logic j, logic [15:0] a, logic [15:0] c);
    return a >= 16'h0800 || (j && (sec[13] || sec[0]))
      || (c != 16'h0001 && sec[12]) || (c == 16'h0002 && sec[8 + a[10:9]]);
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic put(input int a, input logic [31:0] w);
    em[a] = w;
    u_otp.mem[a] = w;
  endtask

  // Valid stays up between writes; the caller drops it
  task automatic wr(input logic [23:0] id, input logic [31:0] d, input logic j);
    int n;
    @(negedge clk);
    port_wr <= '{1'b1, j, id, d};
    n = 0;
    while (port_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(port_ready, 1'b1, "ready");
    @(posedge clk);
  endtask

  task automatic prog(input logic j, input logic [15:0] a,
                      input logic [31:0] d, input logic [15:0] c);
    logic rf;
    int   n;
    rf = refused(j, a, c);
    wr(otp_sec_pkg::RES_ID_ADDR, {16'h0000, a}, j);
    wr(otp_sec_pkg::RES_ID_DATA, d, j);
    wr(otp_sec_pkg::RES_ID_CTRL, {16'h0000, c}, j);
    @(negedge clk);
    port_wr.valid <= 1'b0;
    n = 0;
    while (prog_done !== 1'b1 && prog_rd_valid !== 1'b1
           && prog_refused !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({prog_refused, prog_done, prog_rd_valid},
        {rf, !rf && c != 16'h0001, !rf && c == 16'h0001},
        "answer");
    if (!rf && c == 16'h0002) em[a] = em[a] | d;
    if (!rf && c == 16'h0001) chk(prog_rdata, em[a], "read data");
  endtask

  // md: 0 skip trailer, 1 good check, 2 bad check, 3 oversize count
  task automatic boot(input logic [31:0] ctl, input int cnt, input int md);
    logic [31:0] c, w;
    int          n;
    sec = (rnd() & 32'hFFFF_8000) | ctl;
    w = rnd();
    reset <= 1'b1;
    slow <= w[0];
    boot_mode_pins <= w[3:1];
    u_otp.sec_row = sec;
    img.delete();
    widx = 0;
    if (sec[5]) begin
      put(0, cnt);
      c = crc_step(otp_sec_pkg::CRC_INIT, cnt);
      for (int i = 1; i <= cnt && md != 3; i++) begin
        w = rnd();
        put(i, w);
        img.push_back(w);
        c = crc_step(c, w);
      end
      if (md != 3) put(cnt + 1, md == 0 ? otp_sec_pkg::CRC_SKIP
                                        : md == 1 ? ~c : c);
    end
    repeat (5) @(negedge clk);
    reset <= 1'b0;
    n = 0;
    while (proc_release !== 1'b1 && boot_failed !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(proc_release, md < 2, "release");
    chk(boot_failed, md >= 2, "failure");
    chk(widx, (sec[5] && md != 3) ? cnt : 0, "write count");
    chk(tile_security_config, sec, "security word");
    chk({gp_field, user_ident_extension},
        {sec[21:15], sec[31:22]}, "fields");
    chk({boot_from_otp, boot_mode}, sec[5] ? 4'h8
        : {1'b0, boot_mode_pins}, "boot source");
  endtask

  task automatic gates();
    logic [31:0] w;
    repeat (6) begin
      w = rnd();
      jtag_req <= w[0];
      link_req <= w[1];
      debug_break <= w[2];
      ext_n <= w[3];
      repeat (3) @(negedge clk);
      chk({jtag_grant, link_grant, debug_n_oe, debug_enter, debug_n_o},
          {w[0] & ~sec[0], w[1] & ~sec[1], w[2] & ~sec[14],
           ~sec[14] & (~w[3] | w[2]), 1'b0}, "gates");
    end
  endtask

  initial begin
    foreach (em[i]) em[i] = 32'h0000_0000;
  end

  always @(posedge clk) begin
    if (sram_we === 1'b1) begin
      chk(32'(sram_addr), widx, "sram addr");
      chk(sram_wdata, img[widx], "sram data");
      widx++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    boot(32'h0000_4023, 3, 0);
    gates();
    prog(1'b1, 16'h0300, 32'h0, 16'h0001);
    boot(32'h0000_0020, 5, 1);
    gates();
    prog(1'b1, 16'h0301, 32'h0, 16'h0001);
    boot(32'h0000_0020, 4, 2);
    boot(32'h0000_0020, 2047, 3);
    boot(32'h0000_2180, 0, 0);
    gates();
    prog(1'b0, 16'h02A5, rnd(), 16'h0002);
    prog(1'b0, 16'h02A5, 32'h0, 16'h0001);
    prog(1'b0, 16'h0005, rnd(), 16'h0002);
    prog(1'b0, 16'h0005, 32'h0, 16'h0001);
    prog(1'b1, 16'h0310, 32'h0, 16'h0001);
    prog(1'b0, 16'h0800, rnd(), 16'h0002);
    prog(1'b0, 16'h0000, rnd(), 16'h0003);
    chk(tile_security_config, sec, "live word");
    boot(32'h0000_1000, 0, 0);
    prog(1'b0, 16'h04A0, rnd(), 16'h0002);
    prog(1'b0, 16'h0000, rnd(), 16'h0003);
    prog(1'b0, 16'h04A0, 32'h0, 16'h0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
